/* File: ee_slave.sv */
// Two-wire serial slave with a 2K x 8 storage array and timed page programming.
//
// Operation
// - First byte: type, address top, direction.
// - Data falling while clock high starts.
// - Data rising while clock high stops.
// - Bytes of eight; receiver acks ninth clock.
// - No acknowledge on ninth clock aborts.
// - Write acks device, address, data bytes.
// - Read: ack address, send, master acks.
// - Read advances address counter per byte.
// - Write bits sampled on clock rise.
// - Read bits shifted out on fall.
// - Address: three high bits, then eight.
// - Low address byte only in writes.
// - Stop launches programming; inputs then ignored.
// - Page write takes sixteen bytes, incrementing.
// - Program only when stop follows acknowledge.
// - Protect pin blocks upper half writes.
// - Open protect pin reads as zero.
// - No ack while programming; poll for end.
// - Programming ends within ten milliseconds.
// - Reset ignores commands, writes nothing.
// - Array of 128 pages, 16 bytes.
// - Counter holds last address plus one.
// - Sequential read wraps to address zero.
`timescale 1ns/10ps
`default_nettype none

module ee_slave #(
   // Arbitrary value; the type code the slave answers to.
   parameter logic [3:0] DEV_TYPE_CODE = 4'h6,
   parameter int unsigned PROG_CYCLES = ee_pkg::PROG_CYCLES
) (
   // System clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Two-wire bus.
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Write protect pin.
   input wire logic wp
);

   // Link domain: bit capture on the rise, drive update on the fall.
   logic rx_bit_link;
   logic pull_link;
   // System domain.
   logic scl_s1, scl_s2, scl_prev;
   logic sda_s1, sda_s2, sda_prev;
   logic wp_s1, wp_s2;
   logic pull_s1, pull_s2;
   logic start_ev, stop_ev, rise_ev, bit_in;
   ee_pkg::ee_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] byte_now;
   ee_pkg::ee_devbyte_t dev_byte;
   logic [2:0] addr_hi_reg;
   logic [ee_pkg::ADDR_W-1:0] addr_reg;
   logic [7:0] tx_reg;
   logic [7:0] rd_data_reg;
   logic pull_req_reg;
   logic got_data_reg;
   logic busy_reg;
   logic commit;
   logic [ee_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
   logic [ee_pkg::PAGE_OFS_W:0] prog_idx_reg;
   logic [ee_pkg::PAGE_NUM_W-1:0] prog_page_reg;
   logic [7:0] page_buf [ee_pkg::PAGE_BYTES];
   logic [ee_pkg::PAGE_BYTES-1:0] buf_valid_reg;
   logic sda_oe_reg;
   logic [7:0] mem [ee_pkg::MEM_BYTES];

   // rising edge sampling
   // The captured bit is stable for a whole clock period of the link and is read only
   // after the synchronised clock level shows the rise, so it crosses as bundled data.
   always_ff @(posedge scl) begin
      rx_bit_link <= sda_in;
   end

   // falling edge shift
   // The request is settled during the high phase, well before this edge.
   always_ff @(negedge scl) begin
      pull_link <= pull_req_reg;
   end

   // Pin synchronisers; the first stage of each feeds only the second.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_prev <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_prev <= 1'b1;
         wp_s1 <= 1'b0;
         wp_s2 <= 1'b0;
         pull_s1 <= 1'b0;
         pull_s2 <= 1'b0;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_prev <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_prev <= sda_s2;
         // open pin low
         // The pad carries a weak pulldown, so an open pin arrives here as zero.
         wp_s1 <= wp;
         wp_s2 <= wp_s1;
         pull_s1 <= pull_link;
         pull_s2 <= pull_s1;
      end
   end

   assign start_ev = scl_s2 && scl_prev && sda_prev && !sda_s2;
   assign stop_ev = scl_s2 && scl_prev && !sda_prev && sda_s2;
   assign rise_ev = scl_s2 && !scl_prev;
   assign bit_in = rx_bit_link;
   assign byte_now = {shift_reg[6:0], bit_in};
   assign dev_byte = ee_pkg::ee_devbyte_t'(byte_now);

   // stop after acknowledge
   // The stop sits in the clock after the acknowledge; that clock's rise has already moved the
   // bit counter from zero to one. A stop inside a byte, or a write with no data, changes nothing.
   assign commit = stop_ev && (state_reg == ee_pkg::ST_WDATA) && (bit_cnt_reg == 4'h1)
                   && got_data_reg && !busy_reg
                   && !(wp_s2 && addr_reg[ee_pkg::ADDR_W-1]);

   // Transfer state and bit counter.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= ee_pkg::ST_IDLE;
         bit_cnt_reg <= ee_pkg::BIT_CNT_RESET;
         shift_reg <= ee_pkg::BYTE_RESET;
      end else if (stop_ev) begin
         state_reg <= ee_pkg::ST_IDLE;
      end else if (start_ev) begin
         bit_cnt_reg <= ee_pkg::BIT_CNT_RESET;
         state_reg <= busy_reg ? ee_pkg::ST_IDLE : ee_pkg::ST_DEV;
      end else if (rise_ev && state_reg != ee_pkg::ST_IDLE) begin
         bit_cnt_reg <= (bit_cnt_reg == ee_pkg::ACK_BIT) ? 4'h0 : bit_cnt_reg + 4'h1;
         shift_reg <= byte_now;
         case (state_reg)
            ee_pkg::ST_DEV: begin
               if (bit_cnt_reg == ee_pkg::LAST_DATA_BIT &&
                   (dev_byte.type_code != DEV_TYPE_CODE || busy_reg)) begin
                  state_reg <= ee_pkg::ST_IDLE;
               end else if (bit_cnt_reg == ee_pkg::ACK_BIT) begin
                  state_reg <= shift_reg[0] ? ee_pkg::ST_RDATA : ee_pkg::ST_ADDR;
               end
            end
            ee_pkg::ST_ADDR: begin
               if (bit_cnt_reg == ee_pkg::ACK_BIT) begin
                  state_reg <= ee_pkg::ST_WDATA;
               end
            end
            ee_pkg::ST_RDATA: begin
               if (bit_cnt_reg == ee_pkg::ACK_BIT && bit_in) begin
                  state_reg <= ee_pkg::ST_IDLE;
               end
            end
            ee_pkg::ST_WDATA: begin
            end
            default: begin
               state_reg <= ee_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Drive request toward the link and the transmit shifter.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pull_req_reg <= 1'b0;
         tx_reg <= ee_pkg::BYTE_RESET;
      end else if (start_ev || stop_ev) begin
         pull_req_reg <= 1'b0;
      end else if (rise_ev) begin
         pull_req_reg <= 1'b0;
         case (state_reg)
            ee_pkg::ST_DEV: begin
               if (bit_cnt_reg == ee_pkg::LAST_DATA_BIT) begin
                  pull_req_reg <= (dev_byte.type_code == DEV_TYPE_CODE) && !busy_reg;
               end else if (bit_cnt_reg == ee_pkg::ACK_BIT && shift_reg[0]) begin
                  tx_reg <= rd_data_reg;
                  pull_req_reg <= !rd_data_reg[7];
               end
            end
            ee_pkg::ST_ADDR, ee_pkg::ST_WDATA: begin
               pull_req_reg <= (bit_cnt_reg == ee_pkg::LAST_DATA_BIT);
            end
            ee_pkg::ST_RDATA: begin
               if (bit_cnt_reg < ee_pkg::LAST_DATA_BIT) begin
                  pull_req_reg <= !tx_reg[6];
                  tx_reg <= {tx_reg[6:0], 1'b0};
               end else if (bit_cnt_reg == ee_pkg::ACK_BIT && !bit_in) begin
                  tx_reg <= rd_data_reg;
                  pull_req_reg <= !rd_data_reg[7];
               end
            end
            default: begin
               pull_req_reg <= 1'b0;
            end
         endcase
      end
   end

   // Address counter and page latches.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         addr_reg <= ee_pkg::ADDR_RESET;
         addr_hi_reg <= 3'h0;
         buf_valid_reg <= '0;
         got_data_reg <= 1'b0;
      end else if (commit || stop_ev || start_ev) begin
         if (!commit) begin
            got_data_reg <= 1'b0;
         end
         // blocked write frees the latches at once
         if (stop_ev && !commit) begin
            buf_valid_reg <= '0;
         end
      end else if (rise_ev && bit_cnt_reg == ee_pkg::LAST_DATA_BIT) begin
         case (state_reg)
            ee_pkg::ST_DEV: begin
               if (!dev_byte.rd) begin
                  addr_hi_reg <= dev_byte.addr_hi;
               end
            end
            ee_pkg::ST_ADDR: begin
               addr_reg <= {addr_hi_reg, byte_now};
               buf_valid_reg <= '0;
            end
            ee_pkg::ST_WDATA: begin
               buf_valid_reg[addr_reg[ee_pkg::PAGE_OFS_W-1:0]] <= 1'b1;
               got_data_reg <= 1'b1;
               addr_reg[ee_pkg::PAGE_OFS_W-1:0] <= addr_reg[ee_pkg::PAGE_OFS_W-1:0] + 4'h1;
            end
            ee_pkg::ST_RDATA: begin
               addr_reg <= addr_reg + 11'h001;
            end
            default: begin
               got_data_reg <= got_data_reg;
            end
         endcase
      end else if (busy_reg && prog_idx_reg[ee_pkg::PAGE_OFS_W]) begin
         buf_valid_reg <= '0;
      end
   end

   // Page latch data; a byte sent twice to the same slot keeps the later one.
   always_ff @(posedge clk) begin
      if (rise_ev && bit_cnt_reg == ee_pkg::LAST_DATA_BIT && state_reg == ee_pkg::ST_WDATA) begin
         page_buf[addr_reg[ee_pkg::PAGE_OFS_W-1:0]] <= byte_now;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy_reg <= 1'b0;
         prog_cnt_reg <= '0;
         prog_idx_reg <= '0;
         prog_page_reg <= '0;
      end else if (commit) begin
         busy_reg <= 1'b1;
         prog_cnt_reg <= '0;
         prog_idx_reg <= '0;
         prog_page_reg <= addr_reg[ee_pkg::ADDR_W-1:ee_pkg::PAGE_OFS_W];
      end else if (busy_reg) begin
         prog_cnt_reg <= prog_cnt_reg + 32'h1;
         if (!prog_idx_reg[ee_pkg::PAGE_OFS_W]) begin
            prog_idx_reg <= prog_idx_reg + 5'h01;
         end
         if (prog_cnt_reg == PROG_CYCLES - 1) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // One latched byte reaches the array per cycle; the rest of the time is the cell timer.
   always_ff @(posedge clk) begin
      if (busy_reg && !prog_idx_reg[ee_pkg::PAGE_OFS_W] &&
          buf_valid_reg[prog_idx_reg[ee_pkg::PAGE_OFS_W-1:0]]) begin
         mem[{prog_page_reg, prog_idx_reg[ee_pkg::PAGE_OFS_W-1:0]}] <=
            page_buf[prog_idx_reg[ee_pkg::PAGE_OFS_W-1:0]];
      end
   end

   always_ff @(posedge clk) begin
      rd_data_reg <= mem[addr_reg];
   end

   // Open-drain output: the pin is only ever pulled low.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sda_oe_reg <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         sda_oe_reg <= pull_s2 && (state_reg != ee_pkg::ST_IDLE) && !start_ev && !stop_ev;
         sda_out <= 1'b0;
      end
   end
   assign sda_oe = sda_oe_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_busy_stays_idle: assert property (busy_reg |-> state_reg == ee_pkg::ST_IDLE)
      else $error("state left idle while programming");
   a_start_to_dev: assert property (
      start_ev && !busy_reg && !stop_ev |=> state_reg == ee_pkg::ST_DEV)
      else $error("start did not open a transfer");
   a_stop_to_idle: assert property (stop_ev |=> state_reg == ee_pkg::ST_IDLE)
      else $error("stop did not return to standby");
   a_prog_bounded: assert property (busy_reg |-> prog_cnt_reg < PROG_CYCLES)
      else $error("programming ran past its time");
   a_prog_after_ack: assert property ($rose(busy_reg) |->
      $past(stop_ev && bit_cnt_reg == 4'h1 && state_reg == ee_pkg::ST_WDATA && got_data_reg))
      else $error("programming began without a stop after acknowledge");
   a_wp_blocks: assert property (
      stop_ev && wp_s2 && addr_reg[10] && !busy_reg |=> !busy_reg)
      else $error("protected write started programming");
   a_read_advance: assert property (rise_ev && state_reg == ee_pkg::ST_RDATA
      && bit_cnt_reg == 4'h7 && !stop_ev && !start_ev
      |=> addr_reg == $past(addr_reg) + 11'h001)
      else $error("read did not advance the address");
   a_page_wrap: assert property (rise_ev && state_reg == ee_pkg::ST_WDATA
      && bit_cnt_reg == 4'h7 && !stop_ev && !start_ev
      |=> addr_reg[10:4] == $past(addr_reg[10:4]))
      else $error("page write left its page");
   a_nack_abort: assert property (rise_ev && state_reg == ee_pkg::ST_RDATA
      && bit_cnt_reg == 4'h8 && bit_in && !stop_ev && !start_ev
      |=> state_reg == ee_pkg::ST_IDLE ##1 !sda_oe_reg)
      else $error("missing acknowledge did not abort");
   a_write_ack: assert property (rise_ev && bit_cnt_reg == 4'h7
      && !stop_ev && !start_ev
      && (state_reg == ee_pkg::ST_ADDR || state_reg == ee_pkg::ST_WDATA) |=> pull_req_reg)
      else $error("write byte not acknowledged");

   c_page_prog: cover property ($rose(busy_reg));
   c_read_nack: cover property (rise_ev && state_reg == ee_pkg::ST_RDATA && bit_cnt_reg == 4'h8 && bit_in);
   c_poll_busy: cover property (start_ev && busy_reg);
   c_wp_block: cover property (stop_ev && wp_s2 && state_reg == ee_pkg::ST_WDATA && got_data_reg);

endmodule // ee_slave

`default_nettype wire

/* File: ee_pkg.sv */
// Constants and types shared by the two-wire memory slave.
package ee_pkg;

   // Storage geometry.
   localparam int ADDR_W = 11;
   localparam int MEM_BYTES = 2048;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_COUNT = 128;
   localparam int PAGE_OFS_W = 4;
   localparam int PAGE_NUM_W = 7;

   // Bus framing: bit counter value of the last data bit and of the acknowledge bit.
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;

   // Reset values.
   localparam logic [10:0] ADDR_RESET = 11'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Programming cycle time, longest allowed, rounded down to whole clock cycles.
   localparam int CLK_HZ = 200_000_000;
   localparam int PROG_TIME_MS = 10;
   localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
   localparam int PROG_CNT_W = 32;

   // Transfer phases of the slave.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_ADDR,
      ST_WDATA,
      ST_RDATA
   } ee_state_t;

   // Layout of the first byte after a start.
   typedef struct packed {
      logic [3:0] type_code;
      logic [2:0] addr_hi;
      logic rd;
   } ee_devbyte_t;

endpackage

/* File: ee_master.sv */
// Behavioural two-wire bus master that drives the serial clock.
`timescale 1ns/10ps
`default_nettype none

module ee_master (
   // Phase reference only.
   input wire logic clk,
   // Bus lines; the data line is pulled up.
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // The bus clock stands high between frames and its edges sit off the system clock edges.
   task automatic start();
      @(posedge clk);
      #1.3;
      if (!scl) begin
         sda_pull = 1'b0;
         #20 scl = 1'b1;
         #20;
      end
      sda_pull = 1'b1;
      #20 scl = 1'b0;
      #20;
   endtask

   task automatic stop();
      sda_pull = 1'b1;
      #20 scl = 1'b1;
      #20 sda_pull = 1'b0;
      #40;
   endtask

   task automatic send_bit(input logic b);
      sda_pull = !b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask

   task automatic recv_bit(output logic b);
      sda_pull = 1'b0;
      #20 scl = 1'b1;
      #20 b = sda;
      #20 scl = 1'b0;
      #20;
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) send_bit(d[i]);
      recv_bit(b);
      ack = !b;
   endtask

   task automatic read_byte(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) recv_bit(d[i]);
      send_bit(!more);
   endtask
endmodule // ee_master
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/10ps
`default_nettype none

module testbench;
   localparam int PROG = 200;
   // Arbitrary type code the slave is built to answer.
   localparam logic [3:0] TYPE_CODE = 4'h6;
   logic clk;
   logic rstn;
   logic wp;
   logic scl;
   logic m_pull;
   logic sda_out;
   logic sda_oe;
   wire logic sda;
   logic [7:0] shadow [0:2047];
   logic [10:0] ctr;
   int err_count;
   int checks;
   int cycles = 0;

   // Open drain wire with a pull-up: low while either side pulls.
   assign sda = !((sda_oe && !sda_out) || m_pull);

   ee_slave #(.DEV_TYPE_CODE(TYPE_CODE), .PROG_CYCLES(PROG)) dut (
      .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .wp(wp));
   ee_master m (.clk(clk), .scl(scl), .sda_pull(m_pull), .sda(sda));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         err_count++;
      end
   endtask

   task automatic dev(input logic [10:0] a, input logic rd, output logic ok);
      m.start();
      m.write_byte({TYPE_CODE, a[10:8], rd}, ok);
   endtask

   task automatic do_write(input logic [10:0] a, input int n, input logic [7:0] d0,
         input logic prog);
      logic k;
      dev(a, 1'b0, k);
      check("write dev ack", {7'h0, k}, 8'h01);
      m.write_byte(a[7:0], k);
      check("write addr ack", {7'h0, k}, 8'h01);
      for (int i = 0; i < n; i++) begin
         m.write_byte(d0 + 8'(i), k);
         check("data ack", {7'h0, k}, 8'h01);
         if (prog) shadow[{a[10:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
      end
      m.stop();
      dev(a, 1'b0, k);
      m.stop();
      check("poll at once", {7'h0, k}, {7'h0, !prog});
      repeat (PROG + 50) @(posedge clk);
      dev(a, 1'b0, k);
      m.stop();
      check("poll later", {7'h0, k}, 8'h01);
      if (prog) ctr = {a[10:4], a[3:0] + 4'(n)};
   endtask

   // A random read first loads the counter with an address-only write.
   task automatic do_read(input logic [10:0] a, input int n, input logic rnd);
      logic k;
      logic [7:0] d;
      if (rnd) begin
         dev(a, 1'b0, k);
         m.write_byte(a[7:0], k);
         check("dummy addr ack", {7'h0, k}, 8'h01);
         ctr = a;
      end
      dev(ctr, 1'b1, k);
      check("read dev ack", {7'h0, k}, 8'h01);
      for (int i = 0; i < n; i++) begin
         m.read_byte(i != n - 1, d);
         check("read data", d, shadow[ctr]);
         ctr = ctr + 11'h001;
      end
      #40;
      check("released after nack", {7'h0, sda_oe}, 8'h00);
      m.stop();
   endtask

   task automatic reset_ignores();
      logic k;
      rstn <= 1'b0;
      dev(11'h000, 1'b0, k);
      m.stop();
      check("ack in reset", {7'h0, k}, 8'h00);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic late_stop();
      logic k;
      dev(11'h123, 1'b0, k);
      m.write_byte(8'h23, k);
      m.write_byte(8'h5a, k);
      m.send_bit(1'b1);
      m.send_bit(1'b0);
      m.stop();
      dev(11'h123, 1'b0, k);
      m.stop();
      check("late stop idle", {7'h0, k}, 8'h01);
      do_read(11'h123, 1, 1'b1);
   endtask

   task automatic foreign_type();
      logic k;
      m.start();
      m.write_byte({4'h5, 3'h0, 1'b0}, k);
      m.stop();
      check("foreign type", {7'h0, k}, 8'h00);
   endtask

   initial begin
      rstn = 1'b0;
      // An open protect pin reads as zero.
      wp = 1'b0;
      err_count = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      reset_ignores();
      foreign_type();
      do_write(11'h123, 1, 8'ha5, 1'b1);
      do_read(11'h123, 1, 1'b1);
      do_write(11'h24e, 3, 8'h30, 1'b1);
      do_read(11'h240, 1, 1'b1);
      do_read(11'h24e, 2, 1'b1);
      do_write(11'h330, 16, 8'h80, 1'b1);
      do_read(11'h330, 16, 1'b1);
      do_write(11'h500, 1, 8'h11, 1'b1);
      @(posedge clk);
      wp <= 1'b1;
      do_write(11'h500, 1, 8'h22, 1'b0);
      do_write(11'h010, 1, 8'h33, 1'b1);
      @(posedge clk);
      wp <= 1'b0;
      do_read(11'h500, 1, 1'b1);
      do_read(11'h010, 1, 1'b1);
      do_write(11'h7ff, 1, 8'h7e, 1'b1);
      do_write(11'h000, 2, 8'h40, 1'b1);
      do_read(11'h7ff, 2, 1'b1);
      do_read(11'h000, 1, 1'b0);
      late_stop();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
